// [orx_map.vh]
// orx_map.vh: constants for the or/return execution block
// assumes inclusion by bare name from the design files
`ifndef ORX_MAP_VH
`define ORX_MAP_VH
`define ORX_OP_NONE    3'h0
`define ORX_OP_OR_MEM  3'h1
`define ORX_OP_OR_IMM  3'h2
`define ORX_OP_OR_TOM  3'h3
`define ORX_OP_RET     3'h4
`define ORX_OP_RET_IMM 3'h5
`define ORX_OP_INTERRUPT_RETURN_OP    3'h6
`define ORX_ZERO8      8'h00
`define ORX_PC_RST     13'h0000
`define ORX_VEC_RST    13'h0004
`define ORX_ST_IDLE    3'h1
`define ORX_ST_EXEC    3'h2
`define ORX_ST_VECT    3'h4
`endif

// [orx_alu.v]
// orx_alu.v: combinational or unit with zero detect
// assumes both operands are stable in the same cycle
`timescale 1ns/10ps
`include "orx_map.vh"
module orx_alu (
    input  wire [7:0] a,
    input  wire [7:0] b,
    output wire [7:0] y,
    output wire       zero
);
    assign y    = a | b;
    assign zero = (y == `ORX_ZERO8);
endmodule // orx_alu

// [orx_exec.v]
// orx_exec.v: execution of or and return instructions for an 8-bit core
// assumes decode presents one op per valid pulse and stack data with it
// Contract
// - or with memory puts accumulator or memory byte into the accumulator and updates zero.
// - or with immediate puts accumulator or immediate into the accumulator and updates zero.
// - the memory-target variant writes accumulator or memory byte back to data memory.
// - plain return loads the pc from the stack pop and leaves flags alone.
// - return with immediate loads the pc from the stack and the accumulator with the immediate.
// - interrupt return loads the pc from the stack and sets the master interrupt enable.
// - no interrupt is entered while the master interrupt enable is clear.
// - a request already pending at the edge before the interrupt return is taken is vectored before the main program resumes.
`timescale 1ns/10ps
`include "orx_map.vh"
module orx_exec (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        op_valid,
    input  wire [2:0]  op_code,
    input  wire [7:0]  imm_data,
    input  wire [7:0]  mem_rdata,
    input  wire [12:0] stack_top,
    input  wire        irq_pending,
    input  wire        irq_vector_en,
    input  wire [12:0] irq_vector,
    input  wire        emi_set,
    input  wire        emi_clr,
    output reg  [7:0]  accumulator_reg,
    output reg         zero_flag_q,
    output reg         master_irq_enable,
    output reg  [12:0] pc_q,
    output reg         pc_load_q,
    output reg         stack_pop_q,
    output reg         stack_push_q,
    output reg  [12:0] stack_push_data_q,
    output reg         mem_we_q,
    output reg  [7:0]  mem_wdata_q,
    output reg         irq_ack_q,
    output reg  [2:0]  state_q
);
    // one-hot states of the issue and vector sequence
    localparam [2:0] ST_IDLE = `ORX_ST_IDLE;
    localparam [2:0] ST_EXEC = `ORX_ST_EXEC;
    localparam [2:0] ST_VECT = `ORX_ST_VECT;

    wire [7:0]  alu_b;
    wire [7:0]  or_y;
    wire        or_zero;
    reg  [2:0]  state_d;
    // next values of the architectural registers
    reg  [7:0]  acc_d;
    reg         zero_d;
    reg         emi_d;
    reg  [12:0] pc_d;
    reg         irq_sync1_q;
    reg         irq_sync2_q;
    wire        take_op;
    wire        take_irq;
    wire        enter_vec;
    wire        dec_or_mem;
    wire        dec_or_imm;
    wire        dec_or_tom;
    wire        dec_ret;
    wire        dec_ret_imm;
    wire        dec_interrupt_return_op;
    wire        dec_ret_any;
    wire        dec_or_acc;

    // an op is accepted only from idle; the busy cycles refuse it silently
    assign take_op     = op_valid & (state_q == ST_IDLE);
    assign dec_or_mem  = take_op & (op_code == `ORX_OP_OR_MEM);
    assign dec_or_imm  = take_op & (op_code == `ORX_OP_OR_IMM);
    assign dec_or_tom  = take_op & (op_code == `ORX_OP_OR_TOM);
    assign dec_ret     = take_op & (op_code == `ORX_OP_RET);
    assign dec_ret_imm = take_op & (op_code == `ORX_OP_RET_IMM);
    assign dec_interrupt_return_op    = take_op & (op_code == `ORX_OP_INTERRUPT_RETURN_OP);
    assign dec_ret_any = dec_ret | dec_ret_imm | dec_interrupt_return_op;
    assign dec_or_acc  = dec_or_mem | dec_or_imm;

    // second operand: immediate for the immediate form, memory byte otherwise
    assign alu_b = (op_code == `ORX_OP_OR_IMM) ? imm_data : mem_rdata;

    orx_alu u_alu (
        .a    (accumulator_reg),
        .b    (alu_b),
        .y    (or_y),
        .zero (or_zero)
    );

    // the request line comes from the interrupt logic outside this clock path
    always @(posedge ref_clk) begin
        if (srst) begin
            irq_sync1_q <= 1'b0;
            irq_sync2_q <= 1'b0;
        end else begin
            irq_sync1_q <= irq_pending & irq_vector_en;
            irq_sync2_q <= irq_sync1_q;
        end
    end

    assign take_irq  = irq_sync2_q & master_irq_enable;
    assign enter_vec = (state_q == ST_EXEC) & take_irq;

    // vectoring is decided in the cycle after every accepted op
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (op_valid)
                    state_d = ST_EXEC;
            end
            ST_EXEC: begin
                state_d = take_irq ? ST_VECT : ST_IDLE;
            end
            ST_VECT: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequence state
    always @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // accumulator or results update both, memory-target or updates zero only, return with immediate loads the accumulator only
    always @* begin
        acc_d  = accumulator_reg;
        zero_d = zero_flag_q;
        if (dec_or_acc) begin
            acc_d  = or_y;
            zero_d = or_zero;
        end
        if (dec_or_tom)
            zero_d = or_zero;
        if (dec_ret_imm)
            acc_d = imm_data;
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            accumulator_reg <= `ORX_ZERO8;
            zero_flag_q     <= 1'b0;
        end else begin
            accumulator_reg <= acc_d;
            zero_flag_q     <= zero_d;
        end
    end

    // memory-target or: one write pulse, accumulator kept
    always @(posedge ref_clk) begin
        if (srst) begin
            mem_we_q    <= 1'b0;
            mem_wdata_q <= `ORX_ZERO8;
        end else begin
            mem_we_q <= dec_or_tom;
            if (dec_or_tom)
                mem_wdata_q <= or_y;
        end
    end

    // software set wins over clear; vector entry clears last so a routine is not re-entered
    always @* begin
        emi_d = master_irq_enable;
        if (emi_clr)
            emi_d = 1'b0;
        if (emi_set)
            emi_d = 1'b1;
        if (dec_interrupt_return_op)
            emi_d = 1'b1;
        if (enter_vec)
            emi_d = 1'b0;
    end

    // master interrupt enable
    always @(posedge ref_clk) begin
        if (srst)
            master_irq_enable <= 1'b0;
        else
            master_irq_enable <= emi_d;
    end

    // returns and vector entry never fall in the same cycle
    always @* begin
        pc_d = pc_q;
        if (dec_ret_any)
            pc_d = stack_top;
        if (enter_vec)
            pc_d = irq_vector;
    end

    // pc and stack strobes, one-cycle pulses
    always @(posedge ref_clk) begin
        if (srst) begin
            pc_q              <= `ORX_PC_RST;
            pc_load_q         <= 1'b0;
            stack_pop_q       <= 1'b0;
            stack_push_q      <= 1'b0;
            stack_push_data_q <= `ORX_PC_RST;
            irq_ack_q         <= 1'b0;
        end else begin
            pc_q         <= pc_d;
            pc_load_q    <= dec_ret_any | enter_vec;
            stack_pop_q  <= dec_ret_any;
            stack_push_q <= enter_vec;
            irq_ack_q    <= enter_vec;
            if (enter_vec) begin
                // the current pc_q goes back on the stack so the main program resumes after the routine
                stack_push_data_q <= pc_q;
            end
        end
    end
endmodule // orx_exec

// [orx_exec_checker.sv]
// orx_exec_checker.sv: port checks of the or/return execution block
// assumes one clock and a synchronous reset, bound onto orx_exec
`timescale 1ns/10ps
module orx_exec_checker (
    input logic        ref_clk,
    input logic        srst,
    input logic        op_valid,
    input logic        irq_pending,
    input logic        irq_vector_en,
    input logic [2:0]  op_code,
    input logic [2:0]  state_q,
    input logic [7:0]  imm_data,
    input logic [7:0]  mem_rdata,
    input logic [7:0]  accumulator_reg,
    input logic [7:0]  mem_wdata_q,
    input logic [12:0] stack_top,
    input logic [12:0] pc_q,
    input logic        zero_flag_q,
    input logic        master_irq_enable,
    input logic        pc_load_q,
    input logic        stack_pop_q,
    input logic        mem_we_q,
    input logic        irq_ack_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire t = op_valid && state_q == 3'h1;
    wire p = irq_pending & irq_vector_en;
    property p_or_mem; t && op_code == 3'h1 |=> accumulator_reg == ($past(accumulator_reg) | $past(mem_rdata))
        && zero_flag_q == (accumulator_reg == 8'h00); endproperty
    a_or_mem: assert property (p_or_mem) else $error("or mem wrong");
    property p_or_imm; t && op_code == 3'h2 |=> accumulator_reg == ($past(accumulator_reg) | $past(imm_data));
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("or imm wrong");
    property p_or_tom; t && op_code == 3'h3 |=> mem_we_q && $stable(accumulator_reg)
        && mem_wdata_q == ($past(accumulator_reg) | $past(mem_rdata)); endproperty
    a_or_tom: assert property (p_or_tom) else $error("or to mem wrong");
    property p_ret; t && op_code == 3'h4 |=> pc_load_q && stack_pop_q && pc_q == $past(stack_top)
        && $stable(zero_flag_q); endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_ret_imm; t && op_code == 3'h5 |=> accumulator_reg == $past(imm_data) && pc_q == $past(stack_top);
    endproperty
    a_ret_imm: assert property (p_ret_imm) else $error("return imm wrong");
    property p_interrupt_return_op; t && op_code == 3'h6 |=> master_irq_enable && stack_pop_q && $stable(zero_flag_q); endproperty
    a_interrupt_return_op: assert property (p_interrupt_return_op) else $error("irq return wrong");
    property p_gate; irq_ack_q |-> $past(master_irq_enable); endproperty
    a_gate: assert property (p_gate) else $error("irq taken while disabled");
    property p_vect; state_q == 3'h2 && master_irq_enable && p && $past(p) && $past(p, 2)
        |=> irq_ack_q && state_q == 3'h4; endproperty
    a_vect: assert property (p_vect) else $error("pending irq not vectored");
    cover property (irq_ack_q);
    cover property (mem_we_q);
    cover property (t && op_code == 3'h6);
endmodule // orx_exec_checker
bind orx_exec orx_exec_checker i_orx_exec_checker (.*);

// [or_and_return_instr_exec_tb.sv]
// or_and_return_instr_exec_tb.sv: random and corner tests of orx_exec
// assumes the hand-over timing: result registered at the taken edge, checked half a cycle later
`timescale 1ns/10ps
module or_and_return_instr_exec_tb;
    reg         ref_clk = 0, srst = 1, op_valid = 0, irq_pending = 0, irq_vector_en = 1, emi_set = 0, emi_clr = 0;
    reg  [2:0]  op_code = 0;
    reg  [7:0]  imm_data = 0, mem_rdata = 0, accumulator_reg_unused, ea = 0;
    reg  [12:0] stack_top = 0, irq_vector = 13'h0100;
    reg         ez = 0, em = 0;
    wire [7:0]  accumulator_reg, mem_wdata_q;
    wire [12:0] pc_q, stack_push_data_q;
    wire [2:0]  state_q;
    wire        zero_flag_q, master_irq_enable, pc_load_q, stack_pop_q, stack_push_q, mem_we_q, irq_ack_q;
    integer     fail_count = 0, cmp_count = 0, i;
    always #20 ref_clk = ~ref_clk;
    orx_exec i_orx_exec (.*);
    function [7:0] nacc(input [2:0] c);
        nacc = c == 3'h1 ? ea | mem_rdata : c == 3'h2 ? ea | imm_data : c == 3'h5 ? imm_data : ea;
    endfunction
    task chk(input [12:0] s, input [12:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    task op(input [2:0] c, input z);
        begin
            @(posedge ref_clk);
            op_valid <= 1'b1;
            op_code <= c;
            {stack_top, mem_rdata, imm_data} <= z ? 29'h0 : 29'($urandom);
            @(posedge ref_clk);
            op_valid <= 1'b0;
            @(negedge ref_clk);
            chk(accumulator_reg, nacc(c));
            if (c == 3'h3) chk(mem_wdata_q, ea | mem_rdata);
            if (c > 3'h0 && c < 3'h4) ez = nacc(c == 3'h3 ? 3'h1 : c) == 8'h00;
            ea = nacc(c);
            em = em | c == 3'h6;
            chk(zero_flag_q, ez);
            chk(mem_we_q, c == 3'h3);
            chk(stack_pop_q, c > 3'h3);
            chk(pc_load_q, c > 3'h3);
            chk(state_q, 3'h2);
            chk(master_irq_enable, em);
            if (c > 3'h3) chk(pc_q, stack_top);
        end
    endtask
    task summarize;
        begin
            $display("compares %0d mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #100000;
        fail_count = fail_count + 1;
        summarize;
    end
    initial begin
        i = $urandom(70259);
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        op(3'h1, 1'b1);
        op(3'h3, 1'b1);
        for (i = 0; i < 300; i = i + 1) op(3'($urandom % 7), 1'b0);
        $display("random ops done");
        @(posedge ref_clk) emi_clr <= 1'b1;
        @(posedge ref_clk) emi_clr <= 1'b0;
        irq_pending <= 1'b1;
        em = 0;
        op(3'h1, 1'b0);
        @(negedge ref_clk) chk(irq_ack_q, 1'b0);
        op(3'h6, 1'b0);
        @(negedge ref_clk) chk(irq_ack_q, 1'b1);
        chk(pc_q, irq_vector);
        chk(stack_push_data_q, stack_top);
        chk(stack_push_q, 1'b1);
        chk(master_irq_enable, 1'b0);
        em = 0;
        @(posedge ref_clk) irq_pending <= 1'b0;
        op(3'h4, 1'b0);
        $display("irq return done");
        @(posedge ref_clk) begin
            emi_set       <= 1'b1;
            emi_clr       <= 1'b1;
            irq_vector_en <= 1'b0;
            irq_pending   <= 1'b1;
        end
        @(posedge ref_clk) begin
            emi_set <= 1'b0;
            emi_clr <= 1'b0;
        end
        em = 1;
        op(3'h2, 1'b0);
        @(negedge ref_clk) chk(irq_ack_q, 1'b0);
        $display("enable gating done");
        summarize;
    end
endmodule // or_and_return_instr_exec_tb
